// File: hdl/measurement_channel_config.sv
// Function
// - uv enable bit 7 fills auxiliary pair
// - auxiliary enable bit 6 fills auxiliary pair
// - bit 5 runs ambient infrared measurement
// - bit 4 runs ambient visible measurement
// - bits 2..0 enable proximity three..one
// - proximity one drives select a bits 2:0
// - proximity two drives select a bits 6:4
// - proximity three drives select b bits 2:0
// - each emitter field bit enables one emitter
// - select a resets to 0x21
// - proximity alignment bits pick low or high
// - proximity alignment resets zero, low nibble zero
// - ambient alignment bits 5,4 pick window
// - parameters reached only by query/set commands
`timescale 1ns/1ps
module measurement_channel_config import measurement_channel_pkg::*; #(
	parameter int ADC_WIDTH = ADC_WIDTH_DEFAULT,
	parameter int RESULT_WIDTH = RESULT_WIDTH_DEFAULT,
	parameter int EMITTER_COUNT = EMITTER_COUNT_DEFAULT
) (
	input wire logic sys_clk_i, // system clock, 10 MHz
	input wire logic reset_i, // synchronous reset, active high
	input wire param_request_t param_req_i, // parameter query/set command
	output logic param_ack_o, // command answered, one cycle
	output logic [7:0] param_rdata_o, // query answer
	input wire logic measure_start_i, // forced or autonomous cycle request
	output logic measure_busy_o, // measurement cycle running
	output logic measure_done_o, // cycle finished, one cycle
	output logic measure_refused_o, // start with empty list, one cycle
	output logic conv_start_o, // start one conversion, one cycle
	output channel_t conv_channel_o, // channel being converted
	input wire logic conv_done_i, // conversion finished
	input wire logic [ADC_WIDTH-1:0] conv_data_i, // raw conversion word
	output logic [2:0] emitter_drive_o, // emitter enables one..three
	output results_t results_o // result byte pairs
);

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	generate
		if (RESULT_WIDTH != 16) begin : g_bad_result
			$error("result pairs hold exactly sixteen bits");
		end
		if (EMITTER_COUNT < 1 || EMITTER_COUNT > 3) begin : g_bad_emitters
			$error("one to three emitter drivers are supported");
		end
	endgenerate

	// drivers missing on a smaller variant never fire
	localparam logic [2:0] EMITTER_PRESENT = 3'((4'h1 << EMITTER_COUNT) - 4'h1);

	// ----------------------------------------------------------------
	// parameter memory
	// ----------------------------------------------------------------
	logic [7:0] channel_enable_list; // which channels run
	logic [7:0] proximity_emitter_select_a; // emitters for prox one and two
	logic [7:0] proximity_emitter_select_b; // emitters for prox three
	logic [7:0] proximity_result_alignment; // prox window selects
	logic [7:0] ambient_result_alignment; // ambient window selects
	logic [7:0] next_channel_enable_list;
	logic [7:0] next_proximity_emitter_select_a;
	logic [7:0] next_proximity_emitter_select_b;
	logic [7:0] next_proximity_result_alignment;
	logic [7:0] next_ambient_result_alignment;
	logic next_param_ack;
	logic [7:0] next_param_rdata;

	// set and query commands are the only way in; no direct address map
	always_comb begin
		next_channel_enable_list = channel_enable_list;
		next_proximity_emitter_select_a = proximity_emitter_select_a;
		next_proximity_emitter_select_b = proximity_emitter_select_b;
		next_proximity_result_alignment = proximity_result_alignment;
		next_ambient_result_alignment = ambient_result_alignment;
		next_param_ack = param_req_i.valid;
		next_param_rdata = param_rdata_o;
		if (param_req_i.valid && param_req_i.write) begin
			// masks keep reserved bits at zero
			unique case (param_req_i.offset)
				CHANNEL_ENABLE_LIST_OFFSET: begin
					next_channel_enable_list = param_req_i.wdata & CHANNEL_ENABLE_LIST_MASK;
				end
				PROXIMITY_EMITTER_SELECT_A_OFFSET: begin
					next_proximity_emitter_select_a =
						param_req_i.wdata & PROXIMITY_EMITTER_SELECT_A_MASK;
				end
				PROXIMITY_EMITTER_SELECT_B_OFFSET: begin
					next_proximity_emitter_select_b =
						param_req_i.wdata & PROXIMITY_EMITTER_SELECT_B_MASK;
				end
				PROXIMITY_RESULT_ALIGNMENT_OFFSET: begin
					next_proximity_result_alignment =
						param_req_i.wdata & PROXIMITY_RESULT_ALIGNMENT_MASK;
				end
				AMBIENT_RESULT_ALIGNMENT_OFFSET: begin
					next_ambient_result_alignment =
						param_req_i.wdata & AMBIENT_RESULT_ALIGNMENT_MASK;
				end
				default: begin
					// other parameters live elsewhere; set is dropped
				end
			endcase
		end
		if (param_req_i.valid) begin
			// a set answers with the value just stored
			unique case (param_req_i.offset)
				CHANNEL_ENABLE_LIST_OFFSET: next_param_rdata = next_channel_enable_list;
				PROXIMITY_EMITTER_SELECT_A_OFFSET: begin
					next_param_rdata = next_proximity_emitter_select_a;
				end
				PROXIMITY_EMITTER_SELECT_B_OFFSET: begin
					next_param_rdata = next_proximity_emitter_select_b;
				end
				PROXIMITY_RESULT_ALIGNMENT_OFFSET: begin
					next_param_rdata = next_proximity_result_alignment;
				end
				AMBIENT_RESULT_ALIGNMENT_OFFSET: begin
					next_param_rdata = next_ambient_result_alignment;
				end
				default: next_param_rdata = 8'h00;
			endcase
		end
	end

	// register the parameter memory and the command answer
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			channel_enable_list <= CHANNEL_ENABLE_LIST_RESET;
			proximity_emitter_select_a <= PROXIMITY_EMITTER_SELECT_A_RESET;
			proximity_emitter_select_b <= PROXIMITY_EMITTER_SELECT_B_RESET;
			proximity_result_alignment <= PROXIMITY_RESULT_ALIGNMENT_RESET;
			ambient_result_alignment <= AMBIENT_RESULT_ALIGNMENT_RESET;
			param_ack_o <= 1'b0;
			param_rdata_o <= 8'h00;
		end else begin
			channel_enable_list <= next_channel_enable_list;
			proximity_emitter_select_a <= next_proximity_emitter_select_a;
			proximity_emitter_select_b <= next_proximity_emitter_select_b;
			proximity_result_alignment <= next_proximity_result_alignment;
			ambient_result_alignment <= next_ambient_result_alignment;
			param_ack_o <= next_param_ack;
			param_rdata_o <= next_param_rdata;
		end
	end

	// ----------------------------------------------------------------
	// per-channel decode
	// ----------------------------------------------------------------
	// emitter field of a channel; each bit is its own emitter enable
	function automatic logic [2:0] emitters_for(input channel_t c);
		logic [2:0] e;
		e = 3'h0;
		unique case (c)
			ch_proximity_one: e = proximity_emitter_select_a[PROXIMITY_ONE_EMITTERS_LSB +: 3];
			ch_proximity_two: e = proximity_emitter_select_a[PROXIMITY_TWO_EMITTERS_LSB +: 3];
			ch_proximity_three: begin
				e = proximity_emitter_select_b[PROXIMITY_THREE_EMITTERS_LSB +: 3];
			end
			default: e = 3'h0; // light channels fire nothing
		endcase
		return e & EMITTER_PRESENT;
	endfunction

	// window choice of a channel; uv and auxiliary have none and keep the top
	function automatic logic low_bits_for(input channel_t c);
		logic b;
		b = 1'b0;
		unique case (c)
			ch_proximity_one: b = proximity_result_alignment[PROXIMITY_ONE_LOW_BITS_BIT];
			ch_proximity_two: b = proximity_result_alignment[PROXIMITY_TWO_LOW_BITS_BIT];
			ch_proximity_three: b = proximity_result_alignment[PROXIMITY_THREE_LOW_BITS_BIT];
			ch_ambient_infrared: b = ambient_result_alignment[AMBIENT_INFRARED_LOW_BITS_BIT];
			ch_ambient_visible: b = ambient_result_alignment[AMBIENT_VISIBLE_LOW_BITS_BIT];
			default: b = 1'b0;
		endcase
		return b;
	endfunction

	// enable list reordered into measurement order
	logic [CHANNEL_COUNT-1:0] list_in_order;
	assign list_in_order = {
		channel_enable_list[PROXIMITY_THREE_ENABLE_BIT],
		channel_enable_list[PROXIMITY_TWO_ENABLE_BIT],
		channel_enable_list[PROXIMITY_ONE_ENABLE_BIT],
		channel_enable_list[AMBIENT_VISIBLE_ENABLE_BIT],
		channel_enable_list[AMBIENT_INFRARED_ENABLE_BIT],
		channel_enable_list[AUXILIARY_ENABLE_BIT],
		channel_enable_list[UV_INDEX_ENABLE_BIT]
	};

	// ----------------------------------------------------------------
	// measurement sequencer
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {st_idle, st_launch, st_wait} seq_state_t;

	seq_state_t state; // sequencer state
	seq_state_t next_state;
	logic [CHANNEL_COUNT-1:0] pending; // channels still to convert
	logic [CHANNEL_COUNT-1:0] next_pending;
	channel_t next_conv_channel;
	logic [2:0] next_emitter_drive;
	logic next_conv_start;
	logic next_measure_done;
	logic next_measure_refused;
	results_t next_results;
	logic [RESULT_WIDTH-1:0] aligned; // converter word cut to sixteen bits
	channel_t pick; // lowest pending channel

	// the converter word is windowed by the current channel's choice
	conversion_aligner #(
		.ADC_WIDTH(ADC_WIDTH),
		.RESULT_WIDTH(RESULT_WIDTH)
	) u_aligner (
		.conversion_i(conv_data_i),
		.low_bits_i(low_bits_for(conv_channel_o)),
		.aligned_o(aligned)
	);

	// lowest set pending bit wins; loop runs downward so it lands lowest
	always_comb begin
		pick = ch_uv_index;
		for (int i = CHANNEL_COUNT - 1; i >= 0; i--) begin
			if (pending[i]) begin
				pick = channel_t'(i[2:0]);
			end
		end
	end

	// sequencing, emitter drive and result capture
	always_comb begin
		next_state = state;
		next_pending = pending;
		next_conv_channel = conv_channel_o;
		next_emitter_drive = emitter_drive_o;
		next_conv_start = 1'b0;
		next_measure_done = 1'b0;
		next_measure_refused = 1'b0;
		next_results = results_o;
		unique case (state)
			st_idle: begin
				if (measure_start_i) begin
					if (list_in_order == '0) begin
						// empty list would loop on nothing; answer and stay idle
						next_measure_refused = 1'b1;
					end else begin
						next_pending = list_in_order; // list is sampled once per cycle
						next_state = st_launch;
					end
				end
			end
			st_launch: begin
				next_conv_channel = pick;
				next_pending[pick] = 1'b0;
				next_emitter_drive = emitters_for(pick);
				next_conv_start = 1'b1;
				next_state = st_wait;
			end
			st_wait: begin
				if (conv_done_i) begin
					next_emitter_drive = 3'h0; // emitters only during their measurement
					unique case (conv_channel_o)
						// uv index and auxiliary share one pair; later one wins
						ch_uv_index, ch_auxiliary: next_results.auxiliary = aligned;
						ch_ambient_infrared: next_results.ambient_infrared = aligned;
						ch_ambient_visible: next_results.ambient_visible = aligned;
						ch_proximity_one: next_results.proximity_one = aligned;
						ch_proximity_two: next_results.proximity_two = aligned;
						ch_proximity_three: next_results.proximity_three = aligned;
					endcase
					if (pending == '0) begin
						next_measure_done = 1'b1;
						next_state = st_idle;
					end else begin
						next_state = st_launch;
					end
				end
			end
		endcase
	end

	// register the sequencer
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			state <= st_idle;
			pending <= '0;
			conv_channel_o <= ch_uv_index;
			emitter_drive_o <= 3'h0;
			conv_start_o <= 1'b0;
			measure_done_o <= 1'b0;
			measure_refused_o <= 1'b0;
			results_o <= '0;
		end else begin
			state <= next_state;
			pending <= next_pending;
			conv_channel_o <= next_conv_channel;
			emitter_drive_o <= next_emitter_drive;
			conv_start_o <= next_conv_start;
			measure_done_o <= next_measure_done;
			measure_refused_o <= next_measure_refused;
			results_o <= next_results;
		end
	end

	assign measure_busy_o = (state != st_idle);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_select_a_reset;
		@(posedge sys_clk_i) disable iff (reset_i)
		$fell(reset_i) |-> proximity_emitter_select_a == 8'h21;
	endproperty
	a_select_a_reset: assert property (p_select_a_reset)
		else $error("emitter select a not 0x21 after reset");

	property p_prox_align_reserved;
		@(posedge sys_clk_i) disable iff (reset_i)
		param_ack_o |-> proximity_result_alignment[3:0] == 4'h0 && !proximity_result_alignment[7];
	endproperty
	a_prox_align_reserved: assert property (p_prox_align_reserved)
		else $error("proximity alignment reserved bits not zero");

	property p_amb_align_reserved;
		@(posedge sys_clk_i) disable iff (reset_i)
		param_ack_o |-> ambient_result_alignment[7:6] == 2'h0 && ambient_result_alignment[3:0] == 4'h0;
	endproperty
	a_amb_align_reserved: assert property (p_amb_align_reserved)
		else $error("ambient alignment reserved bits not zero");

	property p_prox_one_emitters;
		@(posedge sys_clk_i) disable iff (reset_i)
		(state == st_launch && pick == ch_proximity_one)
			|=> conv_start_o && emitter_drive_o == ($past(proximity_emitter_select_a[2:0]) & EMITTER_PRESENT);
	endproperty
	a_prox_one_emitters: assert property (p_prox_one_emitters)
		else $error("proximity one drove wrong emitters");

	property p_prox_two_emitters;
		@(posedge sys_clk_i) disable iff (reset_i)
		(state == st_launch && pick == ch_proximity_two)
			|=> emitter_drive_o == ($past(proximity_emitter_select_a[6:4]) & EMITTER_PRESENT);
	endproperty
	a_prox_two_emitters: assert property (p_prox_two_emitters)
		else $error("proximity two drove wrong emitters");

	property p_prox_three_emitters;
		@(posedge sys_clk_i) disable iff (reset_i)
		(state == st_launch && pick == ch_proximity_three)
			|=> emitter_drive_o == ($past(proximity_emitter_select_b[2:0]) & EMITTER_PRESENT);
	endproperty
	a_prox_three_emitters: assert property (p_prox_three_emitters)
		else $error("proximity three drove wrong emitters");

	property p_idle_dark;
		@(posedge sys_clk_i) disable iff (reset_i)
		(state == st_idle || conv_channel_o < ch_proximity_one) |-> emitter_drive_o == 3'h0;
	endproperty
	a_idle_dark: assert property (p_idle_dark)
		else $error("emitter driven outside a proximity measurement");

	property p_empty_list_refused;
		@(posedge sys_clk_i) disable iff (reset_i)
		(state == st_idle && measure_start_i && channel_enable_list == 8'h00)
			|=> measure_refused_o && state == st_idle ##1 !measure_refused_o;
	endproperty
	a_empty_list_refused: assert property (p_empty_list_refused)
		else $error("empty channel list started a cycle");

	property p_infrared_window;
		@(posedge sys_clk_i) disable iff (reset_i)
		(state == st_wait && conv_done_i && conv_channel_o == ch_ambient_infrared
			&& ambient_result_alignment[5]) |=> results_o.ambient_infrared == $past(conv_data_i[15:0]);
	endproperty
	a_infrared_window: assert property (p_infrared_window)
		else $error("infrared result not taken from low bits");

	property p_uv_to_auxiliary;
		@(posedge sys_clk_i) disable iff (reset_i)
		(state == st_wait && conv_done_i && conv_channel_o == ch_uv_index)
			|=> results_o.auxiliary == $past(conv_data_i[16:1]);
	endproperty
	a_uv_to_auxiliary: assert property (p_uv_to_auxiliary)
		else $error("uv index result not in auxiliary pair");

endmodule

// File: shared/measurement_channel_pkg.sv
package measurement_channel_pkg;

	// ----------------------------------------------------------------
	// parameter offsets within the indirect parameter space
	// ----------------------------------------------------------------
	localparam logic [7:0] CHANNEL_ENABLE_LIST_OFFSET = 8'h01;
	localparam logic [7:0] PROXIMITY_EMITTER_SELECT_A_OFFSET = 8'h02;
	localparam logic [7:0] PROXIMITY_EMITTER_SELECT_B_OFFSET = 8'h03;
	localparam logic [7:0] PROXIMITY_RESULT_ALIGNMENT_OFFSET = 8'h05;
	localparam logic [7:0] AMBIENT_RESULT_ALIGNMENT_OFFSET = 8'h06;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] CHANNEL_ENABLE_LIST_RESET = 8'h00;
	localparam logic [7:0] PROXIMITY_EMITTER_SELECT_A_RESET = 8'h21;
	localparam logic [7:0] PROXIMITY_EMITTER_SELECT_B_RESET = 8'h00;
	localparam logic [7:0] PROXIMITY_RESULT_ALIGNMENT_RESET = 8'h00;
	localparam logic [7:0] AMBIENT_RESULT_ALIGNMENT_RESET = 8'h00;

	// ----------------------------------------------------------------
	// writable bits; reserved bits are held at zero
	// ----------------------------------------------------------------
	localparam logic [7:0] CHANNEL_ENABLE_LIST_MASK = 8'hf7;
	localparam logic [7:0] PROXIMITY_EMITTER_SELECT_A_MASK = 8'h77;
	localparam logic [7:0] PROXIMITY_EMITTER_SELECT_B_MASK = 8'h07;
	localparam logic [7:0] PROXIMITY_RESULT_ALIGNMENT_MASK = 8'h70;
	localparam logic [7:0] AMBIENT_RESULT_ALIGNMENT_MASK = 8'h30;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int UV_INDEX_ENABLE_BIT = 7;
	localparam int AUXILIARY_ENABLE_BIT = 6;
	localparam int AMBIENT_INFRARED_ENABLE_BIT = 5;
	localparam int AMBIENT_VISIBLE_ENABLE_BIT = 4;
	localparam int PROXIMITY_THREE_ENABLE_BIT = 2;
	localparam int PROXIMITY_TWO_ENABLE_BIT = 1;
	localparam int PROXIMITY_ONE_ENABLE_BIT = 0;
	localparam int PROXIMITY_ONE_EMITTERS_LSB = 0;
	localparam int PROXIMITY_TWO_EMITTERS_LSB = 4;
	localparam int PROXIMITY_THREE_EMITTERS_LSB = 0;
	localparam int PROXIMITY_THREE_LOW_BITS_BIT = 6;
	localparam int PROXIMITY_TWO_LOW_BITS_BIT = 5;
	localparam int PROXIMITY_ONE_LOW_BITS_BIT = 4;
	localparam int AMBIENT_INFRARED_LOW_BITS_BIT = 5;
	localparam int AMBIENT_VISIBLE_LOW_BITS_BIT = 4;

	// ----------------------------------------------------------------
	// widths and counts
	// ----------------------------------------------------------------
	localparam int ADC_WIDTH_DEFAULT = 17;
	localparam int RESULT_WIDTH_DEFAULT = 16;
	localparam int EMITTER_COUNT_DEFAULT = 3;
	localparam int CHANNEL_COUNT = 7;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	// measurement order follows the enum order
	typedef enum logic [2:0] {
		ch_uv_index,
		ch_auxiliary,
		ch_ambient_infrared,
		ch_ambient_visible,
		ch_proximity_one,
		ch_proximity_two,
		ch_proximity_three
	} channel_t;

	typedef struct packed {
		logic [7:0] high; // upper result byte
		logic [7:0] low; // lower result byte
	} result_pair_t;

	typedef struct packed {
		result_pair_t auxiliary; // shared by uv index and auxiliary
		result_pair_t ambient_infrared;
		result_pair_t ambient_visible;
		result_pair_t proximity_one;
		result_pair_t proximity_two;
		result_pair_t proximity_three;
	} results_t;

	typedef struct packed {
		logic valid; // command present this cycle
		logic write; // 1 = parameter set, 0 = parameter query
		logic [7:0] offset; // parameter offset
		logic [7:0] wdata; // value for a set
	} param_request_t;

endpackage

// File: hdl/conversion_aligner.sv
`timescale 1ns/1ps
module conversion_aligner import measurement_channel_pkg::*; #(
	parameter int ADC_WIDTH = ADC_WIDTH_DEFAULT,
	parameter int RESULT_WIDTH = RESULT_WIDTH_DEFAULT
) (
	input wire logic [ADC_WIDTH-1:0] conversion_i, // raw converter word
	input wire logic low_bits_i, // 1 = report low bits
	output logic [RESULT_WIDTH-1:0] aligned_o // reported result
);

	// ----------------------------------------------------------------
	// elaboration check
	// ----------------------------------------------------------------
	// a window as wide as the converter would make the choice meaningless
	generate
		if (ADC_WIDTH <= RESULT_WIDTH) begin : g_bad_width
			$error("converter must be wider than the reported result");
		end
	endgenerate

	// ----------------------------------------------------------------
	// window select
	// ----------------------------------------------------------------
	// low window keeps resolution, high window keeps range
	always_comb begin
		if (low_bits_i) begin
			aligned_o = conversion_i[RESULT_WIDTH-1:0];
		end else begin
			aligned_o = conversion_i[ADC_WIDTH-1 -: RESULT_WIDTH];
		end
	end

endmodule

// File: bench/conv_model.sv
`timescale 1ns/1ps
// ------------------------------------------
// converter model at the far side
// ------------------------------------------
module conv_model (
	input wire logic clk_i, // system clock
	input wire logic start_i, // conversion request
	input wire logic [3:0] delay_i, // cycles to answer, 1..15
	input wire logic [16:0] word_i, // word to hand back
	output logic done_o, // conversion finished
	output logic [16:0] data_o // raw conversion word
);
	logic [3:0] cnt; // cycles left, 0 = idle
	initial begin
		done_o = 1'b0;
		data_o = 17'h00000;
		cnt = 4'h0;
	end
	// data toggles outside the done cycle, so a stale sample never matches
	always @(negedge clk_i) begin
		done_o <= 1'b0;
		data_o <= ~data_o;
		if (start_i) begin
			cnt <= delay_i;
		end else if (cnt == 4'h1) begin
			done_o <= 1'b1;
			data_o <= word_i;
			cnt <= 4'h0;
		end else if (cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
		end
	end
endmodule

// File: bench/tb.sv
`timescale 1ns/1ps
module tb import measurement_channel_pkg::*;;
	// ------------------------------------------
	// signals and bench state
	// ------------------------------------------
	logic sys_clk_i = 1'b0; // 10 MHz
	logic reset_i = 1'b1; // synchronous reset
	param_request_t req; // parameter command
	logic ack, start, busy, done, refused, cstart, cdone; // handshakes
	logic [7:0] rdata; // query answer
	channel_t chan; // channel converting
	logic [16:0] cdata; // converter word
	logic [2:0] emit; // emitter enables
	results_t res; // result pairs
	logic [3:0] delay; // converter latency
	logic [16:0] words [0:6]; // word per channel
	logic [7:0] offs [0:4] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h06}; // parameter offsets
	logic [7:0] rst [0:4] = '{8'h00, 8'h21, 8'h00, 8'h00, 8'h00}; // reset values
	logic [7:0] msk [0:4] = '{8'hf7, 8'h77, 8'h07, 8'h70, 8'h30}; // writable bits
	logic [7:0] cur [0:4]; // stored values expected
	logic [7:0] wv; // value written
	int seed = 31, miscompares = 0, checked = 0;
	always #50 sys_clk_i = ~sys_clk_i;
	measurement_channel_config measurement_channel_config_inst (.sys_clk_i(sys_clk_i),
		.reset_i(reset_i), .param_req_i(req), .param_ack_o(ack), .param_rdata_o(rdata),
		.measure_start_i(start), .measure_busy_o(busy), .measure_done_o(done),
		.measure_refused_o(refused), .conv_start_o(cstart), .conv_channel_o(chan),
		.conv_done_i(cdone), .conv_data_i(cdata), .emitter_drive_o(emit), .results_o(res));
	conv_model conv_model_inst (.clk_i(sys_clk_i), .start_i(cstart), .delay_i(delay),
		.word_i(words[chan]), .done_o(cdone), .data_o(cdata));
	// ------------------------------------------
	// expectation helpers and tasks
	// ------------------------------------------
	function automatic int bitof(input int c); // list bit of each channel in run order
		return (c < 4) ? 7 - c : c - 4;
	endfunction
	function automatic logic [15:0] win(input logic [16:0] w, input logic lo); // 16-bit window
		return lo ? w[15:0] : w[16:1];
	endfunction
	function automatic logic [2:0] emit_of(input int c); // emitters for channel
		return (c == 4) ? cur[1][2:0] : (c == 5) ? cur[1][6:4] : (c == 6) ? cur[2][2:0] : 3'h0;
	endfunction
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic test_done();
		if (miscompares == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// one command per cycle, answer checked in the ack cycle; valid stays up for back to back
	task automatic par(input logic wr, input logic [7:0] off, wd, exp);
		req = '{1'b1, wr, off, wd};
		@(negedge sys_clk_i);
		chk("ack", 16'h0001, {15'h0, ack});
		chk("rdata", {8'h0, exp}, {8'h0, rdata});
	endtask
	// one measurement cycle over the stored list, then result pairs
	task automatic run();
		int c;
		c = 0;
		req.valid = 1'b0;
		start = 1'b1;
		@(negedge sys_clk_i);
		start = 1'b0;
		chk("refused", {15'h0, cur[0] == 8'h00}, {15'h0, refused});
		chk("busy", {15'h0, cur[0] != 8'h00}, {15'h0, busy});
		for (int i = 0; i < 300 && cur[0] != 8'h00; i++) begin
			@(negedge sys_clk_i);
			if (cstart === 1'b1) begin
				while (c < 7 && !cur[0][bitof(c)]) c++;
				chk("channel", 16'(c), {13'h0, chan});
				chk("emitters", {13'h0, emit_of(c)}, {13'h0, emit});
				c++;
			end
			if (done === 1'b1) break;
		end
		if (cur[0] == 8'h00) return;
		chk("done", 16'h0001, {15'h0, done});
		if (done !== 1'b1) test_done();
		chk("busy end", 16'h0000, {15'h0, busy});
		while (c < 7 && !cur[0][bitof(c)]) c++;
		chk("channels run", 16'h0007, 16'(c));
		if (cur[0][7] | cur[0][6]) chk("aux", win(words[cur[0][6]], 1'b0), res.auxiliary);
		if (cur[0][5]) chk("amb_ir", win(words[2], cur[4][5]), res.ambient_infrared);
		if (cur[0][4]) chk("amb_vis", win(words[3], cur[4][4]), res.ambient_visible);
		if (cur[0][0]) chk("prox1", win(words[4], cur[3][4]), res.proximity_one);
		if (cur[0][1]) chk("prox2", win(words[5], cur[3][5]), res.proximity_two);
		if (cur[0][2]) chk("prox3", win(words[6], cur[3][6]), res.proximity_three);
	endtask
	// ------------------------------------------
	// main sequence
	// ------------------------------------------
	initial begin
		req = '0;
		start = 1'b0;
		delay = 4'h1;
		cur = rst;
		for (int i = 0; i < 7; i++) words[i] = 17'($random(seed));
		repeat (4) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
		reset_i = 1'b0;
		for (int i = 0; i < 5; i++) par(1'b0, offs[i], 8'h00, rst[i]);
		par(1'b1, 8'h04, 8'hff, 8'h00);
		cur[0] = 8'h03;
		par(1'b1, 8'h01, 8'h03, 8'h03);
		run();
		for (int k = 0; k < 14; k++) begin
			for (int i = 0; i < 5; i++) begin
				wv = 8'($random(seed));
				if (k < 8) wv[2:0] = 3'(k);
				if (k == 8) wv = 8'hff;
				cur[i] = wv & msk[i];
				par(1'b1, offs[i], wv, cur[i]);
			end
			for (int i = 0; i < 7; i++) words[i] = 17'($random(seed));
			delay = 4'h1 + 4'($unsigned($random(seed)) % 4);
			run();
		end
		cur[0] = 8'h00;
		par(1'b1, 8'h01, 8'h08, 8'h00);
		run();
		test_done();
	end
endmodule
